// [hdl/adc_input_config.sv]
// Input configuration fields, conversion sequencing and AHB-Lite registers
//
// Overview of operation
// RULE1 - Pseudo bit: sixteen inputs share common negative
// RULE2 - Pseudo: upper four bits pick positive
// RULE3 - Otherwise all eight channel bits select
// RULE4 - Software writes zero to bits 17, 5
// RULE5 - Temp bit routes internal sensor instead
// RULE6 - Temp low: convert configured input channel
// RULE7 - Sensor has no unique status code
// RULE8 - Each conversion waits full settling time
// RULE9 - Status low nibble names result's channel
// RULE10 - Channel named by positive input terminal
// RULE11 - Burn bit one enables test currents
// RULE12 - Burn bit zero disables test currents
// RULE13 - Currents only with buffer on, chop off
// RULE14 - Reference sense flags reference below 0.6V
// RULE15 - Buffer bit selects buffered inputs
// RULE16 - Chop bit enables chopping, longer settling
// RULE17 - New configuration applies from next conversion
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module adc_input_config
   import adc_cfg_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        ref_low,
   input  wire logic [23:0] sample_data,
   output logic [3:0]       pos_input,
   output logic [3:0]       neg_input,
   output logic             use_common_neg,
   output logic             temp_sel,
   output logic             burn_on,
   output logic             buf_on,
   output logic             chop_on,
   output logic             irq
);
   // Bus address phase capture
   logic       wr_pend_reg, wr_pend_next;
   logic [7:0] wa_reg, wa_next;

   // Registers
   logic [31:0] config_reg, config_next;
   logic [31:0] active_reg, active_next;
   logic [3:0]  chan_reg, chan_next;
   logic [23:0] result_reg, result_next;
   logic        missing_reference_flag_reg, missing_reference_flag_next;
   logic        rdy_reg, rdy_next;
   logic [2:0]  irq_stat_reg, irq_stat_next;
   logic [2:0]  irq_mask_reg, irq_mask_next;
   logic [31:0] hrdata_next;
   conv_state_t state_reg, state_next;

   logic             start;
   logic             settle_done;
   logic [CNT_W-1:0] settle_len;
   logic             burn_blocked;
   logic [2:0]       events;
   logic             take;
   logic             conv_req;
   logic [CNT_W-1:0] settle_cnt_reg;
   logic [CNT_W-1:0] settle_cnt_next;

   function automatic logic [31:0] clean_cfg(input logic [31:0] d);
      logic [31:0] r;
      r             = d;
      r[RSVD17_BIT] = 1'b0;  // RULE4
      r[RSVD5_BIT]  = 1'b0;  // RULE4
      return r;
   endfunction

   adc_input_select u_sel (
      .cfg            (active_reg),
      .pos_input      (pos_input),
      .neg_input      (neg_input),
      .use_common_neg (use_common_neg),
      .temp_sel       (temp_sel),
      .burn_on        (burn_on),
      .burn_blocked   (burn_blocked),
      .buf_on         (buf_on),
      .chop_on        (chop_on)
   );

   adc_settle_timer u_tmr (
      .hclk    (hclk),
      .hresetn (hresetn),
      .start   (start),
      .length  (settle_len),
      .done    (settle_done)
   );

   assign take      = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = |(irq_stat_reg & irq_mask_reg);
   assign conv_req  = wr_pend_reg && wa_reg == CTRL_OFF && hwdata[0];
   assign start     = (state_reg == CV_IDLE) && conv_req;
   // Chop lengthens settling
   assign settle_len = config_reg[CHOP_BIT] ?
                       CNT_W'(SETTLE_CHOP_CYC) : CNT_W'(SETTLE_CYC); // RULE16

   // Bus and register next state
   always_comb begin
      wr_pend_next  = take & hwrite;
      wa_next       = take ? haddr[7:0] : wa_reg;
      config_next   = config_reg;
      irq_mask_next = irq_mask_reg;
      irq_stat_next = irq_stat_reg;
      hrdata_next   = hrdata;
      if (wr_pend_reg) begin
         case (wa_reg)
            CONFIG_OFF:   config_next   = clean_cfg(hwdata);
            IRQ_MASK_OFF: irq_mask_next = hwdata[2:0];
            IRQ_STAT_OFF: irq_stat_next = irq_stat_reg & ~hwdata[2:0];
            default:      ;
         endcase
      end
      irq_stat_next = irq_stat_next | events;  // Set wins over clear
      if (take && !hwrite) begin
         case (haddr[7:0])
            CONFIG_OFF:   hrdata_next = config_reg;
            STATUS_OFF:   hrdata_next = {24'h0, missing_reference_flag_reg, rdy_reg,
                                         2'b00, chan_reg};
            IRQ_STAT_OFF: hrdata_next = {29'h0, irq_stat_reg};
            IRQ_MASK_OFF: hrdata_next = {29'h0, irq_mask_reg};
            CTRL_OFF:     hrdata_next = {31'h0, state_reg != CV_IDLE};
            RESULT_OFF:   hrdata_next = {8'h00, result_reg};
            default:      hrdata_next = 32'h0;
         endcase
      end
   end

   // Conversion sequencing
   always_comb begin
      state_next  = state_reg;
      active_next = active_reg;
      chan_next   = chan_reg;
      result_next = result_reg;
      rdy_next    = rdy_reg;
      events      = 3'h0;
      missing_reference_flag_next  = config_reg[REFSENSE_BIT] & ref_low;  // RULE14
      events[EV_MISSING_REFERENCE_FLAG] = missing_reference_flag_next & ~missing_reference_flag_reg;
      // Result read clears ready; a fresh result below wins
      if (!wr_pend_reg && take && !hwrite && haddr[7:0] == RESULT_OFF) begin
         rdy_next = 1'b0;
      end
      case (state_reg)
         CV_IDLE: begin
            if (conv_req) begin
               active_next = config_reg;                  // RULE17
               state_next  = CV_SETTLE;
               events[EV_BURN_BLOCK] = config_reg[BURN_BIT] &
                  (~config_reg[BUF_BIT] | config_reg[CHOP_BIT]); // RULE13
            end
         end
         CV_SETTLE: begin
            if (settle_done) begin                        // RULE8
               state_next = CV_DONE;
            end
         end
         CV_DONE: begin
            result_next = sample_data;
            // Sensor reuses the positive-terminal code
            chan_next   = active_reg[CH_HI -: 4];  // RULE9 RULE10 RULE7
            rdy_next    = 1'b1;
            events[EV_DONE] = 1'b1;
            state_next  = CV_IDLE;
         end
         default: state_next = CV_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg  <= 1'b0;
         wa_reg       <= 8'h00;
         config_reg   <= CONFIG_RST;
         active_reg   <= CONFIG_RST;
         chan_reg     <= 4'h0;
         result_reg   <= 24'h0;
         missing_reference_flag_reg    <= 1'b0;
         rdy_reg      <= 1'b0;
         irq_stat_reg <= IRQ_RST;
         irq_mask_reg <= IRQ_RST;
         hrdata       <= 32'h0;
         state_reg    <= CV_IDLE;
      end else begin
         wr_pend_reg  <= wr_pend_next;
         wa_reg       <= wa_next;
         config_reg   <= config_next;
         active_reg   <= active_next;
         chan_reg     <= chan_next;
         result_reg   <= result_next;
         missing_reference_flag_reg    <= missing_reference_flag_next;
         rdy_reg      <= rdy_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         hrdata       <= hrdata_next;
         state_reg    <= state_next;
      end
   end

   // Settle cycle count, read only by the settling check
   always_comb begin
      settle_cnt_next = settle_cnt_reg;
      if (start) begin
         settle_cnt_next = '0;
      end else if (state_reg == CV_SETTLE) begin
         settle_cnt_next = settle_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         settle_cnt_reg <= '0;
      end else begin
         settle_cnt_reg <= settle_cnt_next;
      end
   end

   a_pseudo_neg: assert property ( // RULE1
      @(posedge hclk) disable iff (!hresetn)
      use_common_neg |-> neg_input == 4'h0)
      else $error("pseudo mode neg input not common");
   a_pos_upper: assert property ( // RULE2
      @(posedge hclk) disable iff (!hresetn)
      pos_input == active_reg[CH_HI -: 4])
      else $error("positive input not upper channel bits");
   a_full_neg: assert property ( // RULE3
      @(posedge hclk) disable iff (!hresetn)
      !use_common_neg |-> neg_input == active_reg[CH_LO +: 4])
      else $error("differential neg input wrong");
   a_temp_route: assert property ( // RULE5
      @(posedge hclk) disable iff (!hresetn)
      temp_sel == active_reg[TEMP_BIT])
      else $error("temperature selection mismatch");
   a_settle_wait: assert property ( // RULE8
      @(posedge hclk) disable iff (!hresetn)
      start |=> (state_reg == CV_SETTLE) [*8])
      else $error("conversion finished before settling");
   a_settle_len: assert property ( // RULE8
      @(posedge hclk) disable iff (!hresetn)
      state_reg == CV_SETTLE && settle_done |->
         settle_cnt_reg >= (active_reg[CHOP_BIT] ?
         CNT_W'(SETTLE_CHOP_CYC) : CNT_W'(SETTLE_CYC)))
      else $error("settling period cut short");
   a_status_chan: assert property ( // RULE9
      @(posedge hclk) disable iff (!hresetn)
      state_reg == CV_DONE |=> chan_reg == $past(active_reg[CH_HI -: 4]))
      else $error("status channel not from result");
   a_done_flags: assert property ( // RULE9
      @(posedge hclk) disable iff (!hresetn)
      state_reg == CV_DONE |=> rdy_reg && irq_stat_reg[EV_DONE] &&
         result_reg == $past(sample_data))
      else $error("result, ready or done event not set together");
   a_result_hold: assert property ( // RULE9
      @(posedge hclk) disable iff (!hresetn)
      state_reg != CV_DONE |=> $stable(result_reg) && $stable(chan_reg))
      else $error("result or channel changed without a conversion");
   a_ready_clear: assert property ( // RULE9
      @(posedge hclk) disable iff (!hresetn)
      take && !hwrite && !wr_pend_reg && haddr[7:0] == RESULT_OFF &&
         state_reg != CV_DONE |=> !rdy_reg)
      else $error("ready not cleared by result read");
   a_burn_on: assert property ( // RULE11
      @(posedge hclk) disable iff (!hresetn)
      active_reg[BURN_BIT] && active_reg[BUF_BIT] &&
         !active_reg[CHOP_BIT] |-> burn_on)
      else $error("burnout currents not enabled");
   a_burn_guard: assert property ( // RULE13
      @(posedge hclk) disable iff (!hresetn)
      burn_on |-> buf_on && !chop_on)
      else $error("burnout on without buffer or with chop");
   a_burn_block: assert property ( // RULE13
      @(posedge hclk) disable iff (!hresetn)
      burn_blocked |-> !burn_on)
      else $error("blocked burnout request still drives currents");
   a_burn_event: assert property ( // RULE13
      @(posedge hclk) disable iff (!hresetn)
      start && config_reg[BURN_BIT] && !config_reg[BUF_BIT] |=>
         irq_stat_reg[EV_BURN_BLOCK])
      else $error("blocked burnout request not reported");
   a_burn_off: assert property ( // RULE12
      @(posedge hclk) disable iff (!hresetn)
      !active_reg[BURN_BIT] |-> !burn_on)
      else $error("burnout on while disabled");
   a_missing_reference_flag_flag: assert property ( // RULE14
      @(posedge hclk) disable iff (!hresetn)
      config_reg[REFSENSE_BIT] && ref_low |=> missing_reference_flag_reg)
      else $error("missing reference not flagged");
   a_missing_reference_flag_clear: assert property ( // RULE14
      @(posedge hclk) disable iff (!hresetn)
      !(config_reg[REFSENSE_BIT] && ref_low) |=> !missing_reference_flag_reg)
      else $error("missing reference flagged without cause");
   a_missing_reference_flag_event: assert property ( // RULE14
      @(posedge hclk) disable iff (!hresetn)
      events[EV_MISSING_REFERENCE_FLAG] |=> irq_stat_reg[EV_MISSING_REFERENCE_FLAG])
      else $error("missing reference event lost");
   a_cfg_hold: assert property ( // RULE17
      @(posedge hclk) disable iff (!hresetn)
      state_reg == CV_SETTLE |=> $stable(active_reg))
      else $error("active configuration changed mid conversion");
   a_start_latch: assert property ( // RULE17
      @(posedge hclk) disable iff (!hresetn)
      start |=> state_reg == CV_SETTLE && active_reg == $past(config_reg))
      else $error("configuration not latched at conversion start");
   a_buf_follow: assert property ( // RULE15
      @(posedge hclk) disable iff (!hresetn)
      buf_on == active_reg[BUF_BIT])
      else $error("buffer control mismatch");
   a_chop_follow: assert property ( // RULE16
      @(posedge hclk) disable iff (!hresetn)
      chop_on == active_reg[CHOP_BIT])
      else $error("chop control mismatch");
endmodule

// [hdl/adc_input_select.sv]
// Input channel and front-end control decode from a latched configuration
`timescale 1ns/1ps
module adc_input_select
   import adc_cfg_pkg::*;
(
   input  wire logic [31:0] cfg,
   output logic [3:0]       pos_input,
   output logic [3:0]       neg_input,
   output logic             use_common_neg,
   output logic             temp_sel,
   output logic             burn_on,
   output logic             burn_blocked,
   output logic             buf_on,
   output logic             chop_on
);
   always_comb begin
      temp_sel       = cfg[TEMP_BIT];          // RULE5
      use_common_neg = cfg[PSEUDO_BIT];        // RULE1
      pos_input      = cfg[CH_HI -: 4];        // RULE2 RULE10
      if (cfg[PSEUDO_BIT]) begin
         neg_input = 4'h0;                     // RULE1
      end else begin
         neg_input = cfg[CH_LO +: 4];          // RULE3 RULE6
      end
      buf_on       = cfg[BUF_BIT];             // RULE15
      chop_on      = cfg[CHOP_BIT];            // RULE16
      burn_blocked = cfg[BURN_BIT] & (~cfg[BUF_BIT] | cfg[CHOP_BIT]);
      burn_on      = cfg[BURN_BIT] & ~burn_blocked; // RULE11 RULE12 RULE13
   end
endmodule

// [hdl/adc_settle_timer.sv]
// Settling timer: counts the full settling period of one conversion
`timescale 1ns/1ps
module adc_settle_timer
   import adc_cfg_pkg::*;
(
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] length,
   output logic                  done
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             done_next;

   always_comb begin
      cnt_next  = cnt_reg;
      done_next = 1'b0;
      if (start) begin
         cnt_next = length;
      end else if (cnt_reg != '0) begin
         cnt_next  = cnt_reg - 1'b1;
         done_next = (cnt_reg == 12'h001);   // RULE8
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= '0;
         done    <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         done    <= done_next;
      end
   end
endmodule

// [shared/adc_cfg_pkg.sv]
// Package: register map, fields, reset values and timing for input config
package adc_cfg_pkg;
   // Register byte offsets
   localparam logic [7:0] CONFIG_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFF = 8'h0c;
   localparam logic [7:0] CTRL_OFF = 8'h10;
   localparam logic [7:0] RESULT_OFF = 8'h14;
   // Configuration field positions
   localparam int PSEUDO_BIT = 18;
   localparam int RSVD17_BIT = 17;
   localparam int TEMP_BIT = 16;
   localparam int CH_HI = 15;
   localparam int CH_LO = 8;
   localparam int BURN_BIT = 7;
   localparam int REFSENSE_BIT = 6;
   localparam int RSVD5_BIT = 5;
   localparam int BUF_BIT = 4;
   localparam int CHOP_BIT = 23;
   localparam logic [31:0] CONFIG_RST = 32'h0000_0110;
   // Status field positions
   localparam int MISSING_REFERENCE_FLAG_BIT = 7;
   localparam int RDY_BIT = 6;
   // Interrupt event positions
   localparam int EV_DONE = 0;
   localparam int EV_MISSING_REFERENCE_FLAG = 1;
   localparam int EV_BURN_BLOCK = 2;
   localparam logic [2:0] IRQ_RST = 3'h0;
   // Settling times
   localparam int CLK_MHZ = 25;
   localparam int SETTLE_US = 20;
   localparam int SETTLE_CHOP_US = 40;
   localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
   localparam int SETTLE_CHOP_CYC = SETTLE_CHOP_US * CLK_MHZ;
   localparam int CNT_W = 12;
   localparam logic [3:0] TEMP_CODE_DEFAULT = 4'h0;
   typedef enum logic [1:0] {CV_IDLE, CV_SETTLE, CV_DONE} conv_state_t;
endpackage

// [test/adc_input_config_tb_top.sv]
// Self-checking bench for the input configuration block
`timescale 1ns/1ps
module adc_input_config_tb_top
   import adc_cfg_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, ref_low;
   logic        hreadyout, hresp, irq, use_common_neg, temp_sel;
   logic        burn_on, buf_on, chop_on, pr;
   logic [31:0] haddr, hwdata, hrdata, rd, c, c2;
   logic [1:0]  htrans;
   logic [2:0]  hsize, m, ev;
   logic [23:0] sample_data;
   logic [3:0]  pos_input, neg_input;
   logic [12:0] seen_dec;
   integer      seed, mismatches, tests_run, cyc, t0, i, k;

   adc_input_config uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .ref_low(ref_low), .sample_data(sample_data),
      .pos_input(pos_input), .neg_input(neg_input),
      .use_common_neg(use_common_neg), .temp_sel(temp_sel),
      .burn_on(burn_on), .buf_on(buf_on), .chop_on(chop_on), .irq(irq)
   );

   assign seen_dec = {pos_input, neg_input, use_common_neg, temp_sel,
                      burn_on, buf_on, chop_on};

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   always @(posedge hclk) cyc <= cyc + 1;

   // Expected decode of a latched configuration word
   function automatic logic [12:0] dec(input logic [31:0] v);
      logic b;
      b = v[BURN_BIT] & v[BUF_BIT] & ~v[CHOP_BIT];
      dec = {v[15:12], v[PSEUDO_BIT] ? 4'h0 : v[11:8], v[PSEUDO_BIT],
             v[TEMP_BIT], b, v[BUF_BIT], v[CHOP_BIT]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One single-word transfer; read data taken at the data phase's end
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask

   initial begin
      repeat (40000) @(posedge hclk);
      mismatches = mismatches + 1;
      complete_run;
   end

   initial begin
      seed = 32'h7f86;
      mismatches = 0;
      tests_run = 0;
      cyc = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      ref_low = 1'b0;
      sample_data = 24'h0;
      pr = 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({19'h0, seen_dec}, {19'h0, dec(CONFIG_RST)});
      check({31'h0, irq}, 32'h0);
      bus(1'b0, CONFIG_OFF, 32'h0, rd);
      check(rd, CONFIG_RST);
      bus(1'b1, 8'h20, 32'hffff_ffff, rd);
      bus(1'b0, 8'h20, 32'h0, rd);
      check(rd, 32'h0);
      for (i = 0; i < 8; i++) begin
         c = $random(seed) & ~32'h0002_0020;
         k = $random(seed);
         case (i)
            0: c[PSEUDO_BIT] = 1'b1;
            1: c[TEMP_BIT] = 1'b1;
            2: c[23] = 1'b1;
            3: c[BUF_BIT] = 1'b0;
            4: c[CHOP_BIT] = 1'b0;
            default: ;
         endcase
         if (i >= 2 && i <= 4) c[BURN_BIT] = 1'b1;
         if (i == 4) c[BUF_BIT] = 1'b1;
         if (i == 6) c[REFSENSE_BIT] = 1'b1;
         m = k[3:1];
         ref_low <= k[0] | (i == 6);
         sample_data <= 24'($random(seed));
         bus(1'b1, IRQ_STAT_OFF, 32'h7, rd);
         bus(1'b1, IRQ_MASK_OFF, {29'h0, m}, rd);
         bus(1'b1, CONFIG_OFF, c, rd);
         bus(1'b0, CONFIG_OFF, 32'h0, rd);
         check(rd & 32'h0087_fff0, c & 32'h0085_ffd0);
         bus(1'b1, CTRL_OFF, 32'h1, rd);
         t0 = cyc;
         bus(1'b0, CTRL_OFF, 32'h0, rd);
         check({31'h0, rd[0]}, 32'h1);
         check({19'h0, seen_dec}, {19'h0, dec(c)});
         c2 = ~c & 32'h0085_ff50;
         c2[REFSENSE_BIT] = c[REFSENSE_BIT];
         bus(1'b1, CONFIG_OFF, c2, rd);
         rd = 32'h0;
         while (rd[RDY_BIT] !== 1'b1) bus(1'b0, STATUS_OFF, 32'h0, rd);
         check({19'h0, seen_dec}, {19'h0, dec(c)});
         check({31'h0, hresp}, 32'h0);
         check({31'h0, (cyc - t0) >= (c[CHOP_BIT] ? SETTLE_CHOP_CYC
                : SETTLE_CYC)}, 32'h1);
         check({28'h0, rd[3:0]}, {28'h0, c[15:12]});
         check({31'h0, rd[MISSING_REFERENCE_FLAG_BIT]}, {31'h0, c[6] & ref_low});
         bus(1'b0, RESULT_OFF, 32'h0, rd);
         check(rd, {8'h0, sample_data});
         // Reference event only if the flag rose at the config write
         ev = {c[BURN_BIT] & ~(c[BUF_BIT] & ~c[CHOP_BIT]),
               c[REFSENSE_BIT] & ref_low & ~(pr & ref_low), 1'b1};
         bus(1'b0, IRQ_STAT_OFF, 32'h0, rd);
         check(rd & 32'h5, {29'h0, ev & 3'h5});
         check({31'h0, rd[EV_MISSING_REFERENCE_FLAG]}, {31'h0, ev[EV_MISSING_REFERENCE_FLAG]});
         check({31'h0, irq}, {31'h0, |(ev & m)});
         pr = c[REFSENSE_BIT];
      end
      complete_run;
   end
endmodule
